/* src/dmba_consts.svh */
// What this block does
// - Access bank is bank 0 low 96 bytes plus bank 15 top 160 bytes
// - One instruction bit picks the selected bank or the access bank
// - With that bit zero, low part continues directly into high part
// - Sixteen banks; banked direct addressing reaches only the selected bank
// - Bank select low four bits form the address upper four bits
// - Bank select high four bits read zero and ignore writes
// - Unimplemented bank reads return zero and writes are dropped
// - Status flags still update on direct reads and writes to unimplemented banks; moves never update them
// - Each bank holds 256 bytes, offsets zero through FFh
// - File-to-file move ignores bank select, uses full 12-bit addresses
// - Most special registers sit in access bank high part
`ifndef DMBA_CONSTS_SVH
`define DMBA_CONSTS_SVH

// ----------------------------------------
// Address layout
// ----------------------------------------
`define DMBA_ADDR_W 12
`define DMBA_OFS_W 8
`define DMBA_BANK_W 4
`define DMBA_BANK_COUNT 16
`define DMBA_ACC_LOW_BYTES 96
`define DMBA_ACC_HIGH_BYTES 160
`define DMBA_ACC_SPLIT 8'h60
`define DMBA_ACC_LOW_BANK 4'h0
`define DMBA_ACC_HIGH_BANK 4'hF
`define DMBA_IMPL_MASK 16'h803F

// ----------------------------------------
// Bank select register
// ----------------------------------------
`define DMBA_BSEL_ADDR 12'hFE0
`define DMBA_BSEL_RESET 4'h0
`define DMBA_BSEL_HIGH_ZERO 4'h0
`define DMBA_BYTE_ZERO 8'h00

`endif

/* src/dmba_pkg.sv */
`include "dmba_consts.svh"

package dmba_pkg;

	// ----------------------------------------
	// Operation kinds from the decoder
	// ----------------------------------------
	typedef enum logic [1:0] {
		DMBA_OP_READ,
		DMBA_OP_WRITE,
		DMBA_OP_MOVE,
		DMBA_OP_LOAD_BANK
	} dmba_op_e;

	typedef logic [`DMBA_ADDR_W-1:0] dmba_addr_t;

	// Decoder request
	typedef struct packed {
		dmba_op_e op;
		logic bank_mode;
		logic [`DMBA_OFS_W-1:0] offset;
		dmba_addr_t src;
		dmba_addr_t dst;
		logic [7:0] wdata;
	} dmba_req_s;

	// Data RAM strobe group
	typedef struct packed {
		dmba_addr_t addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} dmba_mem_s;

	// Bank presence lookup
	function automatic logic bank_impl(input logic [`DMBA_BANK_COUNT-1:0] mask,
		input logic [`DMBA_BANK_W-1:0] bank);
		bank_impl = mask[bank];
	endfunction

endpackage

/* src/dmba_bank_decode.sv */
`timescale 1ns/1ps
`include "dmba_consts.svh"

module dmba_bank_decode #(
	parameter logic [`DMBA_BANK_COUNT-1:0] IMPL_MASK = `DMBA_IMPL_MASK
) (
	input wire logic bank_mode_i,
	input wire logic [`DMBA_BANK_W-1:0] bank_sel_i,
	input wire logic [`DMBA_OFS_W-1:0] offset_i,
	output logic [`DMBA_ADDR_W-1:0] addr_o,
	output logic impl_o
);

	// ----------------------------------------
	// Direct address formation
	// ----------------------------------------
	// Access bank folds low part of bank 0 onto top of bank 15
	always_comb begin
		if (bank_mode_i) begin
			addr_o = {bank_sel_i, offset_i};
		end else if (offset_i < `DMBA_ACC_SPLIT) begin
			addr_o = {`DMBA_ACC_LOW_BANK, offset_i};
		end else begin
			addr_o = {`DMBA_ACC_HIGH_BANK, offset_i};
		end
		impl_o = dmba_pkg::bank_impl(IMPL_MASK, addr_o[`DMBA_ADDR_W-1 -: `DMBA_BANK_W]);
	end

endmodule

/* src/dmba_addr_gen.sv */
`timescale 1ns/1ps
`include "dmba_consts.svh"

module dmba_addr_gen #(
	parameter logic [`DMBA_BANK_COUNT-1:0] IMPL_MASK = `DMBA_IMPL_MASK,
	parameter logic [`DMBA_ADDR_W-1:0] BSEL_ADDR = `DMBA_BSEL_ADDR
) (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic req_valid_i,
	input wire dmba_pkg::dmba_req_s req_i,
	output logic req_ready_o,
	output dmba_pkg::dmba_mem_s mem_o,
	input wire logic [7:0] mem_rdata_i,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	output logic flag_upd_o,
	output logic [7:0] bank_sel_o
);

	typedef enum logic {
		ST_IDLE,
		ST_MOVE
	} dmba_state_e;

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// Access bank halves must exist, refused at elaboration
	if (IMPL_MASK[`DMBA_BANK_COUNT-1] == 1'b0 || IMPL_MASK[0] == 1'b0) begin : g_mask_chk
		$error("Access bank needs banks 0 and 15 implemented");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	dmba_state_e state_r, state_nxt;
	dmba_pkg::dmba_mem_s mem_r, mem_nxt;
	logic [`DMBA_BANK_W-1:0] bsel_r, bsel_nxt;
	logic [`DMBA_ADDR_W-1:0] mv_dst_r, mv_dst_nxt;
	logic rd_ret_r, rd_ret_nxt;
	logic rd_impl_r, rd_impl_nxt;
	logic rd_bsel_r, rd_bsel_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;
	logic flag_r, flag_nxt;

	logic [`DMBA_ADDR_W-1:0] dir_addr;
	logic dir_impl;
	logic [7:0] src_byte;
	logic take;

	dmba_bank_decode #(
		.IMPL_MASK(IMPL_MASK)
	) u_decode (
		.bank_mode_i(req_i.bank_mode),
		.bank_sel_i(bsel_r),
		.offset_i(req_i.offset),
		.addr_o(dir_addr),
		.impl_o(dir_impl)
	);

	// Handshake and visible outputs
	assign req_ready_o = (state_r == ST_IDLE);
	assign take = req_valid_i && req_ready_o;
	assign mem_o = mem_r;
	assign rd_valid_o = rd_valid_r;
	assign rd_data_o = rd_data_r;
	assign flag_upd_o = flag_r;
	assign bank_sel_o = {`DMBA_BSEL_HIGH_ZERO, bsel_r};

	// Byte seen on the read issued last cycle
	always_comb begin
		if (rd_bsel_r) begin
			src_byte = {`DMBA_BSEL_HIGH_ZERO, bsel_r};
		end else if (rd_impl_r) begin
			src_byte = mem_rdata_i;
		end else begin
			src_byte = `DMBA_BYTE_ZERO;
		end
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		mem_nxt = mem_r;
		mem_nxt.rd = 1'b0;
		mem_nxt.wr = 1'b0;
		bsel_nxt = bsel_r;
		mv_dst_nxt = mv_dst_r;
		rd_ret_nxt = 1'b0;
		rd_impl_nxt = 1'b0;
		rd_bsel_nxt = 1'b0;
		rd_valid_nxt = rd_ret_r;
		rd_data_nxt = rd_ret_r ? src_byte : rd_data_r;
		flag_nxt = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (take) begin
					case (req_i.op)
						dmba_pkg::DMBA_OP_READ: begin
							mem_nxt.addr = dir_addr;
							rd_bsel_nxt = (dir_addr == BSEL_ADDR);
							mem_nxt.rd = dir_impl && !rd_bsel_nxt;
							rd_impl_nxt = dir_impl;
							rd_ret_nxt = 1'b1;
							flag_nxt = 1'b1;
						end
						dmba_pkg::DMBA_OP_WRITE: begin
							mem_nxt.addr = dir_addr;
							mem_nxt.wdata = req_i.wdata;
							flag_nxt = 1'b1;
							if (dir_addr == BSEL_ADDR) begin
								bsel_nxt = req_i.wdata[`DMBA_BANK_W-1:0];
							end else begin
								mem_nxt.wr = dir_impl;
							end
						end
						dmba_pkg::DMBA_OP_MOVE: begin
							mem_nxt.addr = req_i.src;
							rd_bsel_nxt = (req_i.src == BSEL_ADDR);
							rd_impl_nxt = dmba_pkg::bank_impl(IMPL_MASK,
								req_i.src[`DMBA_ADDR_W-1 -: `DMBA_BANK_W]);
							mem_nxt.rd = rd_impl_nxt && !rd_bsel_nxt;
							mv_dst_nxt = req_i.dst;
							state_nxt = ST_MOVE;
						end
						dmba_pkg::DMBA_OP_LOAD_BANK: begin
							bsel_nxt = req_i.wdata[`DMBA_BANK_W-1:0];
						end
						default: begin
							state_nxt = ST_IDLE;
						end
					endcase
				end
			end
			ST_MOVE: begin
				mem_nxt.addr = mv_dst_r;
				mem_nxt.wdata = src_byte;
				if (mv_dst_r == BSEL_ADDR) begin
					bsel_nxt = src_byte[`DMBA_BANK_W-1:0];
				end else begin
					mem_nxt.wr = dmba_pkg::bank_impl(IMPL_MASK,
						mv_dst_r[`DMBA_ADDR_W-1 -: `DMBA_BANK_W]);
				end
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r <= ST_IDLE;
			mem_r <= '0;
			bsel_r <= `DMBA_BSEL_RESET;
			mv_dst_r <= '0;
			rd_ret_r <= 1'b0;
			rd_impl_r <= 1'b0;
			rd_bsel_r <= 1'b0;
			rd_valid_r <= 1'b0;
			rd_data_r <= `DMBA_BYTE_ZERO;
			flag_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			mem_r <= mem_nxt;
			bsel_r <= bsel_nxt;
			mv_dst_r <= mv_dst_nxt;
			rd_ret_r <= rd_ret_nxt;
			rd_impl_r <= rd_impl_nxt;
			rd_bsel_r <= rd_bsel_nxt;
			rd_valid_r <= rd_valid_nxt;
			rd_data_r <= rd_data_nxt;
			flag_r <= flag_nxt;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	a_bank_addr_form: assert property (
		take && req_i.op == dmba_pkg::DMBA_OP_READ && req_i.bank_mode
		|=> mem_o.addr == {$past(bsel_r), $past(req_i.offset)})
		else $error("Banked address not built from bank select");
	a_acc_low_map: assert property (
		take && req_i.op == dmba_pkg::DMBA_OP_READ && !req_i.bank_mode
		&& req_i.offset < `DMBA_ACC_SPLIT
		|=> mem_o.addr[11:8] == `DMBA_ACC_LOW_BANK)
		else $error("Access low offset not mapped to bank 0");
	a_acc_high_map: assert property (
		take && req_i.op == dmba_pkg::DMBA_OP_READ && !req_i.bank_mode
		&& req_i.offset >= `DMBA_ACC_SPLIT
		|=> mem_o.addr[11:8] == `DMBA_ACC_HIGH_BANK)
		else $error("Access high offset not mapped to bank 15");
	a_bsel_high_zero: assert property (
		take && req_i.op == dmba_pkg::DMBA_OP_WRITE && dir_addr == BSEL_ADDR
		|=> bank_sel_o == {`DMBA_BSEL_HIGH_ZERO, $past(req_i.wdata[`DMBA_BANK_W-1:0])})
		else $error("Bank select write kept high bits or was lost");
	a_unimpl_no_wr: assert property (
		mem_o.wr |-> dmba_pkg::bank_impl(IMPL_MASK, mem_o.addr[11:8]))
		else $error("Write issued to an unimplemented bank");
	a_unimpl_rd_zero: assert property (
		take && req_i.op == dmba_pkg::DMBA_OP_READ && !dir_impl
		|=> ##1 rd_valid_o && rd_data_o == `DMBA_BYTE_ZERO)
		else $error("Unimplemented bank read not zero");
	a_flag_still: assert property (
		take && (req_i.op == dmba_pkg::DMBA_OP_READ || req_i.op == dmba_pkg::DMBA_OP_WRITE)
		|=> flag_upd_o)
		else $error("Flag update missing on direct access");
	a_move_seq: assert property (
		take && req_i.op == dmba_pkg::DMBA_OP_MOVE
		|=> mem_o.addr == $past(req_i.src) && !req_ready_o
		##1 mem_o.addr == $past(req_i.dst, 2) && req_ready_o)
		else $error("Move did not use embedded addresses");
	a_load_bank: assert property (
		take && req_i.op == dmba_pkg::DMBA_OP_LOAD_BANK
		|=> bank_sel_o == {4'h0, $past(req_i.wdata[3:0])})
		else $error("Bank literal not loaded");

	c_acc_high_read: cover property (take && req_i.op == dmba_pkg::DMBA_OP_READ
		&& !req_i.bank_mode && req_i.offset >= `DMBA_ACC_SPLIT);
	c_unimpl_write: cover property (take && req_i.op == dmba_pkg::DMBA_OP_WRITE && !dir_impl);
	c_move_done: cover property (state_r == ST_MOVE ##1 state_r == ST_IDLE);
	c_bsel_read: cover property (rd_valid_o && $past(rd_bsel_r));

endmodule

/* tb/dmba_ram_model.sv */
`timescale 1ns/1ps
module dmba_ram_model (
	input wire logic sys_clk_i,
	input wire dmba_pkg::dmba_mem_s mem_i,
	output logic [7:0] rdata_o
);
	logic [7:0] ram [0:4095];
	logic [7:0] last_r = 8'h00;
	// Known fill so untouched bytes are predictable
	initial begin
		for (int i = 0; i < 4096; i++) ram[i] = 8'(i * 7 + 3);
	end
	// Same-cycle read; off a read the line shows the inverse of the last byte
	always_comb begin
		rdata_o = mem_i.rd ? ram[mem_i.addr] : ~last_r;
	end
	// Byte write on the strobe
	always @(posedge sys_clk_i) begin
		if (mem_i.wr) ram[mem_i.addr] <= mem_i.wdata;
		if (mem_i.rd) last_r <= ram[mem_i.addr];
	end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
	localparam logic [15:0] IMPL = 16'h803F;
	logic sys_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic req_valid_i = 1'b0;
	dmba_pkg::dmba_req_s req_i = '0;
	logic req_ready_o, rd_valid_o, flag_upd_o;
	dmba_pkg::dmba_mem_s mem_o;
	logic [7:0] mem_rdata_i, rd_data_o, bank_sel_o;
	logic [7:0] shadow [0:4095];
	logic [3:0] bank = 4'h0;
	logic [31:0] r;
	int n_errors = 0;
	int compares = 0;
	int seed = 32'hBA3D5ACB;

	dmba_addr_gen i_dmba_addr_gen (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
		.mem_o(mem_o), .mem_rdata_i(mem_rdata_i), .rd_valid_o(rd_valid_o),
		.rd_data_o(rd_data_o), .flag_upd_o(flag_upd_o), .bank_sel_o(bank_sel_o));
	dmba_ram_model i_dmba_ram_model (.sys_clk_i(sys_clk_i), .mem_i(mem_o),
		.rdata_o(mem_rdata_i));

	// Clock
	always #5 sys_clk_i = ~sys_clk_i;

	// Compare and count
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Expected direct address
	function automatic logic [11:0] ea(input logic mode, input logic [7:0] ofs);
		if (mode) return {bank, ofs};
		return (ofs < 8'h60) ? {4'h0, ofs} : {4'hF, ofs};
	endfunction

	// One decoder request with its checks
	task automatic run(input dmba_pkg::dmba_op_e op, input logic mode, input logic [7:0] ofs,
		input logic [7:0] wd, input logic [11:0] src, input logic [11:0] dst);
		logic [11:0] a;
		logic hit;
		logic [7:0] e;
		a = ea(mode, ofs);
		hit = IMPL[a[11:8]] && a != 12'hFE0;
		e = (a == 12'hFE0) ? {4'h0, bank} : (hit ? shadow[a] : 8'h00);
		@(posedge sys_clk_i);
		req_valid_i <= 1'b1;
		req_i <= '{op, mode, ofs, src, dst, wd};
		@(posedge sys_clk_i);
		req_valid_i <= 1'b0;
		#1;
		if (op == dmba_pkg::DMBA_OP_READ || op == dmba_pkg::DMBA_OP_WRITE) begin
			chk("flag_upd", 12'h001, {11'h0, flag_upd_o});
			chk("strobe", {11'h0, hit}, {11'h0, mem_o.rd | mem_o.wr});
			if (hit) chk("addr", a, mem_o.addr);
		end
		if (op == dmba_pkg::DMBA_OP_WRITE) begin
			if (hit) chk("wdata", {4'h0, wd}, {4'h0, mem_o.wdata});
			if (hit) shadow[a] = wd;
			if (a == 12'hFE0) bank = wd[3:0];
			chk("bank_sel", {4'h0, 4'h0, bank}, {4'h0, bank_sel_o});
		end else if (op == dmba_pkg::DMBA_OP_LOAD_BANK) begin
			bank = wd[3:0];
			chk("bank_sel", {4'h0, 4'h0, bank}, {4'h0, bank_sel_o});
			chk("flag_upd", 12'h000, {11'h0, flag_upd_o});
		end else if (op == dmba_pkg::DMBA_OP_READ) begin
			@(posedge sys_clk_i);
			#1;
			chk("rd_valid", 12'h001, {11'h0, rd_valid_o});
			chk("rd_data", {4'h0, e}, {4'h0, rd_data_o});
		end else begin
			e = (src == 12'hFE0) ? {4'h0, bank} : (IMPL[src[11:8]] ? shadow[src] : 8'h00);
			hit = IMPL[dst[11:8]] && dst != 12'hFE0;
			chk("ready", 12'h000, {11'h0, req_ready_o});
			chk("move src", src, mem_o.addr);
			chk("move rd", {11'h0, IMPL[src[11:8]] && src != 12'hFE0}, {11'h0, mem_o.rd});
			@(posedge sys_clk_i);
			#1;
			chk("move dst", dst, mem_o.addr);
			chk("move data", {4'h0, e}, {4'h0, mem_o.wdata});
			chk("move wr", {11'h0, hit}, {11'h0, mem_o.wr});
			if (hit) shadow[dst] = e;
			if (dst == 12'hFE0) bank = e[3:0];
			chk("move bank", {4'h0, 4'h0, bank}, {4'h0, bank_sel_o});
		end
	endtask

	// Verdict and end of run
	task automatic test_done();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Watchdog
	initial begin
		#200000;
		n_errors++;
		test_done();
	end

	// Main sequence
	initial begin
		for (int i = 0; i < 4096; i++) shadow[i] = 8'(i * 7 + 3);
		repeat (16) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		chk("reset bank", 12'h000, {4'h0, bank_sel_o});
		chk("reset ready", 12'h001, {11'h0, req_ready_o});
		chk("reset strobes", 12'h000, {9'h0, mem_o.rd, mem_o.wr, flag_upd_o});
		chk("reset rd", 12'h000, {3'h0, rd_valid_o, rd_data_o});
		$display("test reset done");
		run(dmba_pkg::DMBA_OP_WRITE, 1'b0, 8'h5F, 8'h11, 12'h000, 12'h000);
		run(dmba_pkg::DMBA_OP_WRITE, 1'b0, 8'h60, 8'h22, 12'h000, 12'h000);
		run(dmba_pkg::DMBA_OP_READ, 1'b0, 8'h5F, 8'h00, 12'h000, 12'h000);
		run(dmba_pkg::DMBA_OP_READ, 1'b1, 8'hFF, 8'h00, 12'h000, 12'h000);
		run(dmba_pkg::DMBA_OP_LOAD_BANK, 1'b1, 8'h00, 8'hF6, 12'h000, 12'h000);
		run(dmba_pkg::DMBA_OP_WRITE, 1'b1, 8'h10, 8'h33, 12'h000, 12'h000);
		run(dmba_pkg::DMBA_OP_READ, 1'b1, 8'h10, 8'h00, 12'h000, 12'h000);
		run(dmba_pkg::DMBA_OP_WRITE, 1'b0, 8'hE0, 8'hA3, 12'h000, 12'h000);
		run(dmba_pkg::DMBA_OP_READ, 1'b0, 8'hE0, 8'h00, 12'h000, 12'h000);
		run(dmba_pkg::DMBA_OP_MOVE, 1'b1, 8'h00, 8'h00, 12'h05F, 12'h3FF);
		run(dmba_pkg::DMBA_OP_MOVE, 1'b1, 8'h00, 8'h00, 12'hFE0, 12'h100);
		run(dmba_pkg::DMBA_OP_MOVE, 1'b1, 8'h00, 8'h00, 12'h710, 12'hFE0);
		run(dmba_pkg::DMBA_OP_MOVE, 1'b1, 8'h00, 8'h00, 12'h05F, 12'h810);
		$display("test corners done");
		for (int k = 0; k < 400; k++) begin
			r = $random(seed);
			run(dmba_pkg::dmba_op_e'(r[1:0]), r[2], r[10:3], r[18:11],
				{r[23:20], r[31:24]}, {r[27:24], r[19:12]});
		end
		$display("test random done");
		test_done();
	end
endmodule
